// file: mafc_cfg.svh
// Field positions, codes and reset values for the microword field decoder
`ifndef MAFC_CFG_SVH
`define MAFC_CFG_SVH
`define MAFC_UW_W        64
`define MAFC_FN_HI       63
`define MAFC_FN_LO       55
`define MAFC_ST_HI       54
`define MAFC_ST_LO       53
`define MAFC_A_HI        52
`define MAFC_A_LO        50
`define MAFC_B_HI        49
`define MAFC_B_LO        48
`define MAFC_CI_HI       47
`define MAFC_CI_LO       46
`define MAFC_ALU_MODIFIER_HIGH       45
`define MAFC_ALU_MODIFIER_LOW       44
`define MAFC_SH_HI       43
`define MAFC_SH_LO       42
`define MAFC_SEQ_HI      31
`define MAFC_SEQ_LO      30
`define MAFC_STK_HI      29
`define MAFC_STK_LO      28
`define MAFC_TOBJ_HI     25
`define MAFC_TOBJ_LO     24
`define MAFC_SQEN_HI     23
`define MAFC_SQEN_LO     22
`define MAFC_FACT_HI     21
`define MAFC_FACT_LO     20
`define MAFC_BLIT_HI     19
`define MAFC_BLIT_LO     16
`define MAFC_ALIT_HI     15
`define MAFC_ALIT_LO     12
`define MAFC_JADDR_HI    11
`define MAFC_JADDR_LO    0
`define MAFC_SRC_AB      3'h1
`define MAFC_SRC_ZB      3'h3
`define MAFC_FN_ADD      3'h0
`define MAFC_FN_SUB      3'h1
`define MAFC_DEST_NOSH   3'h3
`define MAFC_STS_C       0
`define MAFC_STS_O       1
`define MAFC_STS_Q       2
`define MAFC_STS_M       3
`define MAFC_FIXED_TOP   12'h7FF
`define MAFC_WCS_BASE    12'h800
`define MAFC_WCS_TOP     12'h8FF
`define MAFC_STACK_DEPTH 4
`define MAFC_RST_UADDR   12'h000
`endif

// file: mafc_pkg.sv
// Types shared by the microword field decoder
package mafc_pkg;
    typedef enum logic [1:0] {
        MODE_MICRO = 2'b00,
        MODE_MUL   = 2'b01,
        MODE_DIV   = 2'b10,
        MODE_SHIFT = 2'b11
    } mafc_mode_e;
    typedef enum logic [1:0] {
        SEQ_CONT = 2'b00,
        SEQ_JUMP = 2'b01,
        SEQ_VECT = 2'b10,
        SEQ_RET  = 2'b11
    } mafc_seq_e;
    typedef struct packed {
        logic [2:0] dest;
        logic [2:0] func;
        logic [2:0] src;
    } mafc_alu_s;
    typedef struct packed {
        logic carry;
        logic ovf;
        logic qbit;
        logic zero;
        logic sign;
        logic shift_out;
    } mafc_flags_s;
endpackage

// file: mafc_field_control.sv
// Microword ALU field decoder with status, scratch register, loop counter and sequencer
//
// Notes on behaviour
// - 64-bit microword split into independent control fields.
// - Nine function bits 55-63 reach the ALU after mode modification.
// - Mode 00 passes function, source and destination unmodified.
// - Multiply mode: scratch bit 0 chooses adding A operand or zero.
// - Divide mode: scratch bit 0 chooses adding or subtracting A operand.
// - Shift mode: loop counter and instruction bits 9-10 steer; zero cycle no shift.
// - Status field: 00 hold, 01 arithmetic flags, 11 load low byte from bus.
// - Status code 10 on a shifting microword, or shift mode, loads the shift-out flag.
// - A operand source select by bits 50-52.
// - B operand source select by bits 48-49.
// - Carry input select by bits 46-47.
// - Bits 42-43 pick shift type outside shift instructions.
// - Same bits qualify memory request page table.
// - Scratch register shifts exactly like the ALU register.
// - Next address: jump, continue, or four-deep push/pop stack.
// - Vectored jump: low 4 bits from vector, upper 8 from microword.
// - Six-bit signed loop counter counts toward zero and holds there.
// - Mask generator gives a single one placed by the A operand.
// - Register file addressed by A as level, B as register number.
// - Test set up first, later enabled test evaluates earlier ALU result.
// - Fixed program below octal 4000, writable store octal 4000-4377.
// - Scratch register load beats a shift in the same cycle.
// - Loop counter loads six bus bits, operand-visible two cycles later.
`include "mafc_cfg.svh"
module mafc_field_control (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // Microword and machine state
    input  wire logic [63:0]          uword,
    input  wire logic [10:0]          instr,
    input  wire logic [15:0]          internal_data_bus,
    input  wire logic [3:0]           current_priority_level,
    input  wire logic [3:0]           vector_in,
    // Commands decoded elsewhere
    input  wire logic                 load_scratch_register_cmd,
    input  wire logic                 load_loop_counter_cmd,
    input  wire logic                 loop_count_en,
    // ALU slice results of the cycle on the outputs
    input  wire mafc_pkg::mafc_flags_s alu_flags,
    // ALU control
    output logic [8:0]                alu_func_q,
    output logic [3:0]                a_operand_q,
    output logic [3:0]                b_operand_q,
    output logic                      carry_in_q,
    output logic [1:0]                shift_type_q,
    output logic [1:0]                page_table_q,
    output logic [15:0]               mask_q,
    output logic [7:0]                rf_addr_q,
    // Held state
    output logic [7:0]                status_word_lo_q,
    output logic [15:0]               scratch_shift_register_q,
    output logic [5:0]                loop_counter_q,
    // Sequencer
    output logic [11:0]               uaddr_q,
    output logic                      writable_microstore_sel_q,
    output logic                      uaddr_fault_q,
    output logic                      test_true_q
);
    wire logic [8:0]  fn_raw   = uword[`MAFC_FN_HI:`MAFC_FN_LO];
    wire logic [1:0]  st_code  = uword[`MAFC_ST_HI:`MAFC_ST_LO];
    wire logic [2:0]  a_sel    = uword[`MAFC_A_HI:`MAFC_A_LO];
    wire logic [1:0]  b_sel    = uword[`MAFC_B_HI:`MAFC_B_LO];
    wire logic [1:0]  ci_sel   = uword[`MAFC_CI_HI:`MAFC_CI_LO];
    wire logic [1:0]  sh_bits  = uword[`MAFC_SH_HI:`MAFC_SH_LO];
    wire logic [1:0]  seq_raw  = uword[`MAFC_SEQ_HI:`MAFC_SEQ_LO];
    wire logic [1:0]  stk_op   = uword[`MAFC_STK_HI:`MAFC_STK_LO];
    wire logic [1:0]  seq_en   = uword[`MAFC_SQEN_HI:`MAFC_SQEN_LO];
    wire logic [1:0]  tobj     = uword[`MAFC_TOBJ_HI:`MAFC_TOBJ_LO];
    wire logic [1:0]  fact     = uword[`MAFC_FACT_HI:`MAFC_FACT_LO];
    wire logic [11:0] jaddr    = uword[`MAFC_JADDR_HI:`MAFC_JADDR_LO];
    wire mafc_pkg::mafc_mode_e mode =
        mafc_pkg::mafc_mode_e'({uword[`MAFC_ALU_MODIFIER_HIGH], uword[`MAFC_ALU_MODIFIER_LOW]});

    // State of the cycle whose decode is now on the outputs
    logic [1:0]  st_code_q;
    logic        shift_en_q;
    logic        shift_up_q;
    logic [1:0]  sh_type_q;
    logic        sh_force_q;
    logic [1:0]  tobj_q;
    logic [1:0]  fact_q;
    logic [5:0]  lc_vis_q;
    logic [11:0] stack_q [`MAFC_STACK_DEPTH];
    logic [2:0]  depth_q;

    function automatic logic is_shift(input logic [2:0] dest);
        is_shift = dest[2];
    endfunction

    function automatic logic [5:0] lc_step(input logic [5:0] v);
        if (v == 6'h00) begin
            lc_step = v;
        end else if (v[5]) begin
            lc_step = v + 6'h01;
        end else begin
            lc_step = v - 6'h01;
        end
    endfunction

    // ALU function modification
    mafc_pkg::mafc_alu_s fn_in;
    mafc_pkg::mafc_alu_s fn_mod;
    assign fn_in = mafc_pkg::mafc_alu_s'(fn_raw);
    wire logic lc_zero  = (loop_counter_q == 6'h00);
    wire logic lc_neg   = loop_counter_q[5];
    always_comb begin
        fn_mod = fn_in;
        case (mode)
            mafc_pkg::MODE_MICRO: fn_mod = fn_in;
            mafc_pkg::MODE_MUL:
                fn_mod.src = scratch_shift_register_q[0] ? `MAFC_SRC_AB : `MAFC_SRC_ZB;
            mafc_pkg::MODE_DIV:
                fn_mod.func = scratch_shift_register_q[0] ? `MAFC_FN_SUB : `MAFC_FN_ADD;
            // counter steers direction; zero stops shift
            mafc_pkg::MODE_SHIFT: begin
                if (lc_zero) begin
                    fn_mod.dest = `MAFC_DEST_NOSH;
                end else begin
                    fn_mod.dest = {1'b1, ~lc_neg, fn_in.dest[0]};
                end
            end
            default: fn_mod = fn_in;
        endcase
    end

    wire logic [1:0] sh_type_d = (mode == mafc_pkg::MODE_SHIFT) ? instr[10:9] : sh_bits;

    // A operand select; counter seen only via delayed copy
    logic [3:0] a_d;
    always_comb begin
        case (a_sel)
            3'h0:    a_d = uword[`MAFC_ALIT_HI:`MAFC_ALIT_LO];
            3'h2:    a_d = current_priority_level;
            3'h4:    a_d = instr[6:3];
            3'h5:    a_d = {1'b0, instr[5:3]};
            3'h6:    a_d = lc_vis_q[3:0];
            default: a_d = 4'h0;
        endcase
    end

    logic [3:0] b_d;
    always_comb begin
        case (b_sel)
            2'h0:    b_d = uword[`MAFC_BLIT_HI:`MAFC_BLIT_LO];
            2'h1:    b_d = {1'b0, instr[2:0]};
            2'h2:    b_d = {1'b0, instr[5:3]};
            default: b_d = lc_vis_q[3:0];
        endcase
    end

    wire logic ci_d = (ci_sel == 2'h0) ? 1'b0 :
                      (ci_sel == 2'h1) ? 1'b1 :
                      (ci_sel == 2'h2) ? status_word_lo_q[`MAFC_STS_C] :
                                         scratch_shift_register_q[0];

    wire logic [15:0] mask_d = 16'h0001 << a_d;

    // status low byte at the close of the output cycle
    logic [7:0] sts_d;
    always_comb begin
        sts_d = status_word_lo_q;
        case (st_code_q)
            2'h1: begin
                sts_d[`MAFC_STS_C] = alu_flags.carry;
                sts_d[`MAFC_STS_O] = alu_flags.ovf;
                sts_d[`MAFC_STS_Q] = alu_flags.qbit;
            end
            2'h3:    sts_d = internal_data_bus[7:0];
            default: sts_d = status_word_lo_q;
        endcase
        // Shift mode catches the lost bit whatever the field says
        if ((st_code_q == 2'h2 && shift_en_q) || sh_force_q) begin
            sts_d[`MAFC_STS_M] = alu_flags.shift_out;
        end
    end

    // scratch register follows the ALU shift; load wins
    logic [15:0] gpr_d;
    logic        fill;
    always_comb begin
        fill = 1'b0;
        gpr_d = scratch_shift_register_q;
        if (load_scratch_register_cmd) begin
            gpr_d = internal_data_bus;
        end else if (shift_en_q) begin
            case (sh_type_q)
                2'h0:    fill = shift_up_q ? 1'b0 : scratch_shift_register_q[15];
                2'h1:    fill = shift_up_q ? scratch_shift_register_q[15] : scratch_shift_register_q[0];
                2'h2:    fill = 1'b0;
                default: fill = status_word_lo_q[`MAFC_STS_C];
            endcase
            gpr_d = shift_up_q ? {scratch_shift_register_q[14:0], fill}
                               : {fill, scratch_shift_register_q[15:1]};
        end
    end

    // counter counts toward zero; load from six bus bits
    wire logic [5:0] lc_d = load_loop_counter_cmd ? internal_data_bus[5:0] :
                            (loop_count_en || sh_force_q) ? lc_step(loop_counter_q) : loop_counter_q;

    // enabled test uses the flags of the earlier operation
    logic [3:0] flag_hold_q;
    wire logic  test_hit = (tobj_q == 2'h0) ? flag_hold_q[0] :
                           (tobj_q == 2'h1) ? flag_hold_q[1] :
                           (tobj_q == 2'h2) ? flag_hold_q[2] : flag_hold_q[3];
    wire logic seq_on    = (seq_en == 2'h3);
    wire logic test_en   = (seq_en == 2'h2);
    wire logic test_fail = test_en && !test_hit;

    wire logic [11:0] top  = stack_q[depth_q[1:0] - 2'h1];
    wire logic [11:0] incr = uaddr_q + 12'h001;
    logic [11:0] next_d;
    always_comb begin
        next_d = incr;
        if (test_en) begin
            next_d = test_hit ? jaddr : ((fact_q == 2'h1 && depth_q != 3'h0) ? top : incr);
        end else if (seq_on) begin
            case (mafc_pkg::mafc_seq_e'(seq_raw))
                mafc_pkg::SEQ_JUMP: next_d = jaddr;
                mafc_pkg::SEQ_VECT: next_d = {jaddr[11:4], vector_in};
                mafc_pkg::SEQ_RET:  next_d = (depth_q != 3'h0) ? top : incr;
                default:            next_d = incr;
            endcase
        end
    end
    wire logic do_push = seq_on && (stk_op == 2'h1) && (depth_q != 3'(`MAFC_STACK_DEPTH));
    wire logic do_pop  = (depth_q != 3'h0) &&
                         ((seq_on && stk_op == 2'h2) || (test_fail && fact_q == 2'h1));

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            alu_func_q               <= 9'h000;
            a_operand_q              <= 4'h0;
            b_operand_q              <= 4'h0;
            carry_in_q               <= 1'b0;
            shift_type_q             <= 2'h0;
            page_table_q             <= 2'h0;
            mask_q                   <= 16'h0001;
            rf_addr_q                <= 8'h00;
            st_code_q                <= 2'h0;
            shift_en_q               <= 1'b0;
            shift_up_q               <= 1'b0;
            sh_type_q                <= 2'h0;
            sh_force_q               <= 1'b0;
        end else begin
            alu_func_q   <= fn_mod;
            a_operand_q  <= a_d;
            b_operand_q  <= b_d;
            carry_in_q   <= ci_d;
            shift_type_q <= sh_type_d;
            page_table_q <= sh_bits;
            mask_q       <= mask_d;
            rf_addr_q    <= {a_d, b_d};
            st_code_q    <= st_code;
            shift_en_q   <= is_shift(fn_mod.dest);
            shift_up_q   <= fn_mod.dest[1];
            sh_type_q    <= sh_type_d;
            sh_force_q   <= (mode == mafc_pkg::MODE_SHIFT);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_word_lo_q         <= 8'h00;
            scratch_shift_register_q <= 16'h0000;
            loop_counter_q           <= 6'h00;
            lc_vis_q                 <= 6'h00;
            flag_hold_q              <= 4'h0;
            tobj_q                   <= 2'h0;
            fact_q                   <= 2'h0;
            test_true_q              <= 1'b0;
        end else begin
            status_word_lo_q         <= sts_d;
            scratch_shift_register_q <= gpr_d;
            loop_counter_q           <= lc_d;
            lc_vis_q                 <= loop_counter_q;
            flag_hold_q              <= {alu_flags.ovf, alu_flags.carry, alu_flags.sign, alu_flags.zero};
            test_true_q              <= test_en && test_hit;
            // Setup of a later test
            if (seq_en == 2'h1) begin
                tobj_q <= tobj;
                fact_q <= fact;
            end
        end
    end

    wire logic in_wcs = (next_d >= `MAFC_WCS_BASE) && (next_d <= `MAFC_WCS_TOP);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            uaddr_q                   <= `MAFC_RST_UADDR;
            writable_microstore_sel_q <= 1'b0;
            uaddr_fault_q             <= 1'b0;
            depth_q                   <= 3'h0;
        end else begin
            uaddr_q                   <= next_d;
            writable_microstore_sel_q <= in_wcs;
            uaddr_fault_q             <= (next_d > `MAFC_FIXED_TOP) && !in_wcs;
            if (do_push) begin
                stack_q[depth_q[1:0]] <= incr;
                depth_q               <= depth_q + 3'h1;
            end else if (do_pop) begin
                depth_q <= depth_q - 3'h1;
            end
        end
    end
endmodule

// file: mafc_store_model.sv
// Control store stand-in presenting the bench's microword each cycle
module mafc_store_model (
    // Clock
    input  wire logic        mclk,
    // Word chosen by the bench
    input  wire logic [63:0] next_word,
    // Microword towards the decoder
    output logic      [63:0] uword
);
    timeunit 1ns;
    timeprecision 1ps;
    // Store output is settled well before each rising edge
    assign uword = next_word;
endmodule

// file: mafc_chk.sv
// Port-level checks for the microword field decoder
module mafc_chk (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Inputs
    input wire logic [63:0] uword,
    input wire logic [15:0] internal_data_bus,
    input wire logic [3:0]  vector_in,
    input wire logic        load_scratch_register_cmd,
    input wire logic        load_loop_counter_cmd,
    // Outputs
    input wire logic [8:0]  alu_func_q,
    input wire logic [3:0]  a_operand_q,
    input wire logic [3:0]  b_operand_q,
    input wire logic        carry_in_q,
    input wire logic [1:0]  shift_type_q,
    input wire logic [15:0] mask_q,
    input wire logic [7:0]  rf_addr_q,
    input wire logic [7:0]  status_word_lo_q,
    input wire logic [15:0] scratch_shift_register_q,
    input wire logic [5:0]  loop_counter_q,
    input wire logic [11:0] uaddr_q
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Status code taken, then bus sampled one cycle later
    sequence s_sts_load;
        uword[54:53] == 2'h3 ##1 1'h1;
    endsequence
    sequence s_vect;
        uword[23:22] == 2'h3 && uword[31:30] == 2'h2;
    endsequence
    a_mask_onehot: assert property (mask_q == 16'h0001 << a_operand_q)
        else $error("mask not one-hot at A");
    a_rf_pair: assert property (rf_addr_q == {a_operand_q, b_operand_q})
        else $error("register file address not A,B");
    a_func_pass: assert property (uword[45:44] == 2'h0 |=> alu_func_q == $past(uword[63:55]))
        else $error("function modified in micro mode");
    a_a_literal: assert property (uword[52:50] == 3'h0 |=> a_operand_q == $past(uword[15:12]))
        else $error("A literal wrong");
    a_b_literal: assert property (uword[49:48] == 2'h0 |=> b_operand_q == $past(uword[19:16]))
        else $error("B literal wrong");
    a_carry_const: assert property (!uword[47] |=> carry_in_q == $past(uword[46]))
        else $error("constant carry wrong");
    a_shift_kind: assert property (uword[45:44] != 2'h3 |=> shift_type_q == $past(uword[43:42]))
        else $error("shift type wrong");
    a_jump_addr: assert property (uword[23:22] == 2'h3 && uword[31:30] == 2'h1
        |=> uaddr_q == $past(uword[11:0])) else $error("jump address wrong");
    a_vect_addr: assert property (s_vect |=> uaddr_q == {$past(uword[11:4]), $past(vector_in)})
        else $error("vector address wrong");
    a_count_hold: assert property (loop_counter_q == 6'h00 && !load_loop_counter_cmd
        |=> loop_counter_q == 6'h00) else $error("counter left zero");
    a_scratch_load: assert property (load_scratch_register_cmd
        |=> scratch_shift_register_q == $past(internal_data_bus)) else $error("scratch load lost");
    a_status_load: assert property (s_sts_load
        |=> status_word_lo_q == $past(internal_data_bus[7:0])) else $error("status byte load wrong");
endmodule
bind mafc_field_control mafc_chk mafc_chk_inst (.mclk(mclk), .rst_n(rst_n), .uword(uword),
    .internal_data_bus(internal_data_bus), .vector_in(vector_in),
    .load_scratch_register_cmd(load_scratch_register_cmd), .load_loop_counter_cmd(load_loop_counter_cmd),
    .alu_func_q(alu_func_q), .a_operand_q(a_operand_q), .b_operand_q(b_operand_q),
    .carry_in_q(carry_in_q), .shift_type_q(shift_type_q), .mask_q(mask_q), .rf_addr_q(rf_addr_q),
    .status_word_lo_q(status_word_lo_q), .scratch_shift_register_q(scratch_shift_register_q),
    .loop_counter_q(loop_counter_q), .uaddr_q(uaddr_q));

// file: tb_top.sv
// Self-checking bench for the microword field decoder
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  mclk;
    logic                  rst_n;
    logic [63:0]           nw;
    logic [63:0]           uword;
    logic [10:0]           instr;
    logic [15:0]           bus_v;
    logic [3:0]            cpl;
    logic [3:0]            vec;
    logic                  ld_scr;
    logic                  ld_lc;
    logic                  cnt_en;
    mafc_pkg::mafc_flags_s flags;
    logic [8:0]            alu_func;
    logic [3:0]            a_op;
    logic [3:0]            b_op;
    logic                  cin;
    logic [1:0]            sh_t;
    logic [1:0]            pg_t;
    logic [15:0]           mask;
    logic [7:0]            rf_a;
    logic [7:0]            stat;
    logic [15:0]           scr;
    logic [5:0]            lc;
    logic [11:0]           ua;
    logic                  ws_sel;
    logic                  flt;
    logic                  tst;
    logic [11:0]           wa [4] = '{12'h7FF, 12'h800, 12'h8FF, 12'h900};
    int                    n_errors = 0;
    int                    num_checks = 0;
    int                    ncyc = 0;

    mafc_store_model mafc_store_model_inst (.mclk(mclk), .next_word(nw), .uword(uword));
    mafc_field_control mafc_field_control_inst (.mclk(mclk), .rst_n(rst_n), .uword(uword),
        .instr(instr), .internal_data_bus(bus_v), .current_priority_level(cpl), .vector_in(vec),
        .load_scratch_register_cmd(ld_scr), .load_loop_counter_cmd(ld_lc), .loop_count_en(cnt_en),
        .alu_flags(flags), .alu_func_q(alu_func), .a_operand_q(a_op), .b_operand_q(b_op),
        .carry_in_q(cin), .shift_type_q(sh_t), .page_table_q(pg_t), .mask_q(mask), .rf_addr_q(rf_a),
        .status_word_lo_q(stat), .scratch_shift_register_q(scr), .loop_counter_q(lc), .uaddr_q(ua),
        .writable_microstore_sel_q(ws_sel), .uaddr_fault_q(flt), .test_true_q(tst));

    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end

    function automatic logic [63:0] mk(input logic [8:0] fn, input logic [1:0] st, input logic [2:0] as,
        input logic [1:0] bs, input logic [1:0] ci, input logic [1:0] md, input logic [43:0] lo);
        return {fn, st, as, bs, ci, md, lo};
    endfunction
    function automatic logic [41:0] sq(input logic [1:0] sel, input logic [1:0] stk, input logic [11:0] ad);
        return {10'h000, sel, stk, 4'h0, 2'h3, 10'h000, ad};
    endfunction
    function automatic logic [3:0] ea(input logic [2:0] c);
        case (c)
            3'h0: return 4'hC;
            3'h2: return cpl;
            3'h4: return instr[6:3];
            3'h5: return {1'h0, instr[5:3]};
            3'h6: return 4'hD;
            default: return 4'h0;
        endcase
    endfunction
    function automatic logic [3:0] eb(input logic [1:0] c);
        case (c)
            2'h0: return 4'h9;
            2'h1: return {1'h0, instr[2:0]};
            2'h2: return {1'h0, instr[5:3]};
            default: return 4'hD;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One microword per cycle, outputs settled at the next falling edge
    task automatic cyc(input logic [63:0] w);
        nw = w;
        @(negedge mclk);
    endtask
    task automatic load_scr(input logic [15:0] v);
        ld_scr = 1'h1;
        bus_v = v;
        cyc(64'h0);
        ld_scr = 1'h0;
    endtask
    task automatic mul_div(input logic g);
        cyc(mk(9'h017, 2'h0, 3'h0, 2'h0, 2'h0, 2'h1, 44'h0));
        chk("mul", g ? 9'h011 : 9'h013, alu_func);
        cyc(mk(9'h017, 2'h0, 3'h0, 2'h0, 2'h0, 2'h2, 44'h0));
        chk("div", g ? 9'h00F : 9'h007, alu_func);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Bound on the whole run
    always @(posedge mclk) begin
        ncyc++;
        if (ncyc == 500) begin
            n_errors++;
            results();
        end
    end

    initial begin
        rst_n = 1'h0;
        nw = 64'h0;
        instr = 11'h2B5;
        bus_v = 16'h0;
        cpl = 4'h7;
        vec = 4'hA;
        ld_scr = 1'h0;
        ld_lc = 1'h0;
        cnt_en = 1'h0;
        flags = 6'h00;
        repeat (4) @(negedge mclk);
        rst_n = 1'h1;
        cyc(mk(9'h000, 2'h3, 3'h0, 2'h0, 2'h0, 2'h0, 44'h0));
        bus_v = 16'h12A5;
        cyc(64'h0);
        chk("status load", 8'hA5, stat);
        flags = 6'h10;
        cyc(mk(9'h000, 2'h1, 3'h0, 2'h0, 2'h0, 2'h0, 44'h0));
        cyc(64'h0);
        chk("status flags", 8'hA2, stat);
        flags = 6'h3F;
        repeat (2) cyc(64'h0);
        chk("status hold", 8'hA2, stat);
        $display("test status done");
        load_scr(16'h0000);
        mul_div(1'h0);
        // Shift word, then load in the cycle it acts
        cyc(mk(9'h100, 2'h0, 3'h0, 2'h0, 2'h0, 2'h0, 44'h0));
        load_scr(16'h0001);
        chk("scratch", 16'h0001, scr);
        mul_div(1'h1);
        cyc(mk(9'h1B5, 2'h0, 3'h0, 2'h0, 2'h0, 2'h0, 44'h0));
        chk("micro fn", 9'h1B5, alu_func);
        $display("test modes done");
        ld_lc = 1'h1;
        bus_v = 16'hFF0D;
        cyc(64'h0);
        ld_lc = 1'h0;
        chk("counter load", 6'h0D, lc);
        // Spare cycle for the counter copy; scratch bit 0 set for carry code 3
        load_scr(16'h0001);
        for (int i = 0; i < 8; i++) begin
            cyc(mk(9'h000, 2'h0, i[2:0], i[1:0], i[1:0], 2'h0, {i[1:0], 22'h0, 20'h9C000}));
            chk("a operand", ea(i[2:0]), a_op);
            chk("b operand", eb(i[1:0]), b_op);
            chk("carry", i[1:0] == 2'h1 || i[1:0] == 2'h3, cin);
            chk("mask", 16'h0001 << ea(i[2:0]), mask);
            chk("rf addr", {ea(i[2:0]), eb(i[1:0])}, rf_a);
            chk("shift type", i[1:0], sh_t);
            chk("page table", i[1:0], pg_t);
        end
        $display("test operands done");
        cnt_en = 1'h1;
        cyc(64'h0);
        chk("count down", 6'h0C, lc);
        cnt_en = 1'h0;
        ld_lc = 1'h1;
        bus_v = 16'h003E;
        cyc(64'h0);
        ld_lc = 1'h0;
        cnt_en = 1'h1;
        cyc(64'h0);
        chk("count up", 6'h3F, lc);
        repeat (2) cyc(64'h0);
        chk("count hold", 6'h00, lc);
        cnt_en = 1'h0;
        $display("test counter done");
        // Shift mode with the counter at zero: no shift, lost bit still caught
        flags = 6'h01;
        cyc(mk(9'h1C0, 2'h0, 3'h0, 2'h0, 2'h0, 2'h3, 44'h0));
        chk("zero count no shift", 9'h0C0, alu_func);
        chk("instr shift type", 2'h1, sh_t);
        cyc(64'h0);
        chk("shift-out flag", 8'hAA, stat);
        ld_lc = 1'h1;
        bus_v = 16'h0003;
        cyc(64'h0);
        ld_lc = 1'h0;
        cyc(mk(9'h000, 2'h0, 3'h0, 2'h0, 2'h0, 2'h3, 44'h0));
        chk("shift mode fn", 9'h180, alu_func);
        cyc(64'h0);
        chk("scratch shift", 16'h0002, scr);
        chk("shift count", 6'h02, lc);
        $display("test shift done");
        cyc({22'h0, sq(2'h1, 2'h0, 12'h123)});
        chk("jump", 12'h123, ua);
        cyc({22'h0, sq(2'h0, 2'h1, 12'h000)});
        chk("continue", 12'h124, ua);
        cyc({22'h0, sq(2'h1, 2'h0, 12'h300)});
        cyc({22'h0, sq(2'h3, 2'h2, 12'h000)});
        chk("return", 12'h124, ua);
        cyc({22'h0, sq(2'h3, 2'h2, 12'h000)});
        chk("empty return", 12'h125, ua);
        cyc({22'h0, sq(2'h2, 2'h0, 12'h45F)});
        chk("vector", 12'h45A, ua);
        // Test set up on zero flag, flags of the setup cycle tested in the cycle after it
        flags = 6'h04;
        cyc(64'h0000_0000_0040_0000);
        cyc(64'h0000_0000_0080_02C3);
        chk("test taken", 12'h2C3, ua);
        chk("test true", 1'h1, tst);
        flags = 6'h00;
        cyc(64'h0);
        cyc(64'h0000_0000_0080_02C3);
        chk("test false", 12'h2C5, ua);
        chk("test untrue", 1'h0, tst);
        foreach (wa[k]) begin
            repeat (2) cyc({22'h0, sq(2'h1, 2'h0, wa[k])});
            chk("store sel", wa[k][11:8] == 4'h8, ws_sel);
            chk("addr fault", wa[k] > 12'h8FF, flt);
        end
        $display("test sequencer done");
        results();
    end
endmodule
